// [src/eeprom_slave.v]
// two-wire slave front end of a 16-Kbit memory with a lockable identification page
//
// Notes on behaviour
// - main array is 2048 bytes, 128 pages of 16, each byte writable
// - separate 16-byte identification page, lockable read-only until rst_in
// - link clock up to 1 MHz; master must not exceed it
// - serial clock captures input bits and times output bits
// - data line is open drain: pull low or release only
// - write protect high refuses all array writes; low allows them
// - under write protect, select and address acked, data bytes not
// - device is slave only, never starts a transfer
// - start is data falling while clock high; precedes every instruction
// - start watched always, except during internal write cycle
// - stop is data rising while clock high; ends communication
// - stop ending a write instruction starts internal write cycle
// - data sampled on each rising serial clock edge
// - transmitter releases after eight bits; receiver acks in ninth clock
// - array select byte: 1010, A10..A8, direction bit
// - select type 1011 targets identification page, b3..b1 ignored
// - bytes travel most significant bit first
// - select bit 0: one means read, zero means write
// - matching select acked in ninth slot; mismatch releases bus, standby
// - array address: A10..A8 from select, A7..A0 from address byte
// - ident address: b7 zero access, one lock; b3..b0 pick byte
// - during write cycle data line released and master ignored
// - only stop right after a data ack slot starts a write
`timescale 1ns/10ps
`include "eeprom_slave_defs.vh"

module eeprom_slave #(
   parameter WRITE_CYC = `WRITE_CYCLE_CYC
)(
   // clock and reset
   input  wire        ref_clk_in,
   input  wire        rst_in,
   // serial link pins
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_out,
   output reg         sda_oe_n_out,
   // write protect pin
   input  wire        write_protect_in,
   // status
   output reg         write_busy_out,
   output reg         ident_locked_out
);

   // ==========================================================
   // state codes, one hot
   // ==========================================================
   localparam [5:0] ST_IDLE = 6'h01;
   localparam [5:0] ST_SEL  = 6'h02;
   localparam [5:0] ST_ADDR = 6'h04;
   localparam [5:0] ST_WDAT = 6'h08;
   localparam [5:0] ST_RDAT = 6'h10;
   localparam [5:0] ST_WAIT = 6'h20;

   // ==========================================================
   // storage
   // ==========================================================
   reg [7:0] array_mem [0:`ARRAY_BYTES-1];
   reg [7:0] ident_mem [0:`PAGE_BYTES-1];
   reg [7:0] pend_mem  [0:`PAGE_BYTES-1];

   // ==========================================================
   // pin synchronisers and edge finding
   // ==========================================================
   reg [1:0] scl_sync_q;
   reg [1:0] sda_sync_q;
   reg [1:0] wp_sync_q;
   reg       scl_prev_q;
   reg       sda_prev_q;

   // all three pins pass two flops; edges are taken from the second stage only
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         wp_sync_q  <= 2'h0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], scl_in};
         sda_sync_q <= {sda_sync_q[0], sda_in};
         wp_sync_q  <= {wp_sync_q[0], write_protect_in};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   wire scl_s    = scl_sync_q[1];
   wire sda_s    = sda_sync_q[1];
   wire scl_rise = scl_s & ~scl_prev_q;
   wire scl_fall = ~scl_s & scl_prev_q;
   wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // ==========================================================
   // protocol registers
   // ==========================================================
   reg [5:0]              state_q;
   reg [3:0]              bit_cnt_q;
   reg [7:0]              shift_q;
   reg                    ident_sel_q;
   reg                    lock_cmd_q;
   reg                    ack_slot_q;
   reg                    ack_low_q;
   reg                    wr_armed_q;
   reg                    wr_ok_q;
   reg                    lock_pend_q;
   reg [`ARRAY_AW-1:0]    addr_q;
   reg [`ARRAY_AW-1:0]    page_base_q;
   reg [`PAGE_BYTES-1:0]  pend_mask_q;
   reg [22:0]             wcyc_cnt_q;
   reg                    master_ack_q;

   // select byte decode, used for the match only; target choice comes from select bit 4
   function sel_match;
      input [7:0] b;
      begin
         sel_match = (b[`SEL_TYPE_HI:`SEL_TYPE_LO] == `SEL_TYPE_MEM) ||
                     (b[`SEL_TYPE_HI:`SEL_TYPE_LO] == `SEL_TYPE_IDENT);
      end
   endfunction

   wire [7:0] rx_byte = {shift_q[6:0], sda_s};
   wire [7:0] rd_byte = ident_sel_q ? ident_mem[addr_q[`IDENT_AW-1:0]]
                                    : array_mem[addr_q];
   wire       wr_allow = ~wp_sync_q[1] &
                         ~(ident_sel_q & ident_locked_out);
   integer i;

   // ==========================================================
   // main protocol machine
   // ==========================================================
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         state_q          <= ST_IDLE;
         bit_cnt_q        <= 4'h0;
         shift_q          <= 8'h00;
         ident_sel_q      <= 1'b0;
         lock_cmd_q       <= 1'b0;
         ack_slot_q       <= 1'b0;
         ack_low_q        <= 1'b0;
         wr_armed_q       <= 1'b0;
         wr_ok_q          <= 1'b0;
         lock_pend_q      <= 1'b0;
         addr_q           <= {`ARRAY_AW{1'b0}};
         page_base_q      <= {`ARRAY_AW{1'b0}};
         pend_mask_q      <= {`PAGE_BYTES{1'b0}};
         wcyc_cnt_q       <= 23'h000000;
         master_ack_q     <= 1'b0;
         sda_out          <= 1'b0;
         sda_oe_n_out     <= 1'b1;
         write_busy_out   <= 1'b0;
         ident_locked_out <= 1'b0;
      end
      else if (write_busy_out)
      begin
         // nonvolatile commit; link fully ignored meanwhile
         sda_oe_n_out <= 1'b1;
         if (wcyc_cnt_q == WRITE_CYC[22:0] - 23'h000001)
         begin
            write_busy_out <= 1'b0;
            wcyc_cnt_q     <= 23'h000000;
            state_q        <= ST_IDLE;
            for (i = 0; i < `PAGE_BYTES; i = i + 1)
               if (pend_mask_q[i])
               begin
                  if (ident_sel_q)
                     ident_mem[i] <= pend_mem[i];
                  else
                     array_mem[{page_base_q[`ARRAY_AW-1:`IDENT_AW], i[3:0]}]
                        <= pend_mem[i];
               end
            if (lock_pend_q)
               ident_locked_out <= 1'b1;
            // counter already stepped past the last modified byte as data came in
            pend_mask_q <= {`PAGE_BYTES{1'b0}};
            lock_pend_q <= 1'b0;
         end
         else
            wcyc_cnt_q <= wcyc_cnt_q + 23'h000001;
      end
      else if (start_ev)
      begin
         // a start outside the write cycle restarts the select phase, even after deselect
         state_q      <= ST_SEL;
         bit_cnt_q    <= 4'h0;
         ack_slot_q   <= 1'b0;
         wr_armed_q   <= 1'b0;
         sda_oe_n_out <= 1'b1;
      end
      else if (stop_ev)
      begin
         state_q      <= ST_IDLE;
         sda_oe_n_out <= 1'b1;
         if (wr_armed_q && (pend_mask_q != {`PAGE_BYTES{1'b0}} || lock_pend_q))
            write_busy_out <= 1'b1;
         else
         begin
            pend_mask_q <= {`PAGE_BYTES{1'b0}};
            lock_pend_q <= 1'b0;
         end
         wr_armed_q <= 1'b0;
      end
      else if (state_q == ST_IDLE || state_q == ST_WAIT)
      begin
         sda_oe_n_out <= 1'b1;
      end
      else if (scl_rise)
      begin
         if (ack_slot_q)
         begin
            master_ack_q <= ~sda_s;
            bit_cnt_q    <= 4'h0;
         end
         else
         begin
            // a read shifts out on the fall only, never in on the rise
            if (state_q != ST_RDAT)
               shift_q <= rx_byte;
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
      end
      else if (scl_fall)
      begin
         // a fall after the ack slot means another bit went by; the stop's
         // own rise must not disarm, or no write could ever start
         if (!ack_slot_q)
            wr_armed_q <= 1'b0;
         // output changes only while the clock is low
         if (ack_slot_q)
         begin
            ack_slot_q   <= 1'b0;
            sda_oe_n_out <= 1'b1;
            if (state_q == ST_WDAT && ack_low_q)
               wr_armed_q <= 1'b1;
            if (state_q == ST_RDAT)
            begin
               if (!master_ack_q && bit_cnt_q == 4'h0 && !ack_low_q)
                  state_q <= ST_WAIT;
               else
               begin
                  sda_out      <= 1'b0;
                  sda_oe_n_out <= rd_byte[7];
                  shift_q      <= {rd_byte[6:0], 1'b0};
               end
            end
            ack_low_q <= 1'b0;
         end
         else if (bit_cnt_q == `SLOT_ACK)
         begin
            ack_slot_q <= 1'b1;
            ack_low_q  <= 1'b0;
            sda_out    <= 1'b0;
            case (state_q)
               ST_SEL:
               begin
                  if (sel_match(shift_q))
                  begin
                     sda_oe_n_out <= 1'b0;
                     ident_sel_q  <= shift_q[`SEL_TYPE_LO];
                     if (shift_q[`SEL_RW_BIT])
                     begin
                        state_q   <= ST_RDAT;
                        ack_low_q <= 1'b1;
                     end
                     else
                     begin
                        state_q <= ST_ADDR;
                        if (!shift_q[`SEL_TYPE_LO])
                           addr_q[`ARRAY_AW-1:8] <= shift_q[3:1];
                     end
                  end
                  else
                  begin
                     state_q      <= ST_WAIT;
                     sda_oe_n_out <= 1'b1;
                  end
               end
               ST_ADDR:
               begin
                  sda_oe_n_out <= 1'b0;
                  state_q      <= ST_WDAT;
                  pend_mask_q  <= {`PAGE_BYTES{1'b0}};
                  lock_pend_q  <= 1'b0;
                  if (ident_sel_q)
                  begin
                     lock_cmd_q <= shift_q[`ADDR_LOCK_BIT];
                     addr_q     <= {7'h00, shift_q[`IDENT_AW-1:0]};
                  end
                  else
                  begin
                     lock_cmd_q <= 1'b0;
                     addr_q[7:0] <= shift_q;
                  end
                  page_base_q <= ident_sel_q ? {`ARRAY_AW{1'b0}}
                                             : {addr_q[`ARRAY_AW-1:8], shift_q};
               end
               ST_WDAT:
               begin
                  if (wr_allow)
                  begin
                     sda_oe_n_out <= 1'b0;
                     ack_low_q    <= 1'b1;
                     if (lock_cmd_q)
                        lock_pend_q <= shift_q[`LOCK_DATA_BIT];
                     else
                     begin
                        pend_mem[addr_q[`IDENT_AW-1:0]] <= shift_q;
                        pend_mask_q[addr_q[`IDENT_AW-1:0]] <= 1'b1;
                        // roll over inside the page
                        addr_q[`IDENT_AW-1:0] <= addr_q[`IDENT_AW-1:0] + 4'h1;
                     end
                  end
                  else
                     sda_oe_n_out <= 1'b1;
               end
               default:
               begin
                  // read: release for master ack, step the counter
                  sda_oe_n_out <= 1'b1;
                  addr_q <= ident_sel_q
                     ? {7'h00, addr_q[`IDENT_AW-1:0] + 4'h1}
                     : addr_q + {{(`ARRAY_AW-1){1'b0}}, 1'b1};
               end
            endcase
         end
         else if (state_q == ST_RDAT && bit_cnt_q != 4'h0)
         begin
            sda_out      <= 1'b0;
            sda_oe_n_out <= shift_q[7];
            shift_q      <= {shift_q[6:0], 1'b0};
         end
      end
   end

endmodule

// [common/eeprom_slave_defs.vh]
// constants for the two-wire memory slave front end
`ifndef EEPROM_SLAVE_DEFS_VH
`define EEPROM_SLAVE_DEFS_VH
// memory organisation
`define PAGE_COUNT        128
`define PAGE_BYTES        16
`define ARRAY_BYTES       2048
`define ARRAY_AW          11
`define IDENT_AW          4
// select byte fields
`define SEL_TYPE_MEM      4'hA
`define SEL_TYPE_IDENT    4'hB
`define SEL_TYPE_HI       7
`define SEL_TYPE_LO       4
`define SEL_RW_BIT        0
`define ADDR_LOCK_BIT     7
`define LOCK_DATA_BIT     1
// bit slot counts
`define SLOT_ACK          4'h8
`define SLOT_LAST_DATA    4'h7
// timing: max link rate and write cycle length
`define LINK_MAX_KHZ      1000
`define CLK_MHZ           200
`define WRITE_CYCLE_US    4000
`define WRITE_CYCLE_CYC   (`WRITE_CYCLE_US * `CLK_MHZ)
`endif

// [bench/eeprom_slave_props.sv]
// checker for the pins of the two-wire memory slave
`timescale 1ns/10ps
module eeprom_slave_props #(
   parameter WRITE_CYC = 200
)(
   // clock and reset
   input wire ref_clk_in,
   input wire rst_in,
   // link pins and status
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_n_out,
   input wire write_protect_in,
   input wire write_busy_out,
   input wire ident_locked_out
);
   // ==========================================================
   // helper logic
   logic [3:0]  since_stop_q;
   logic [31:0] busy_cnt_q;
   logic        scl_q;
   logic        sda_q;
   // cycles since data rose with clock high; saturates so it never wraps
   always_ff @(posedge ref_clk_in)
   begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (rst_in)
         since_stop_q <= 4'hF;
      else if (scl_in && scl_q && sda_in && !sda_q)
         since_stop_q <= 4'h0;
      else if (since_stop_q != 4'hF)
         since_stop_q <= since_stop_q + 4'h1;
   end
   // length of the current write cycle
   always_ff @(posedge ref_clk_in)
   begin
      if (rst_in || !write_busy_out)
         busy_cnt_q <= 32'h0;
      else
         busy_cnt_q <= busy_cnt_q + 32'h1;
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence s_ack_hold;
      !sda_oe_n_out [*6];
   endsequence
   sequence s_stop_recent;
      since_stop_q <= 4'h8;
   endsequence
   a_open_drain: assert property (!sda_oe_n_out |-> !sda_out)
      else $error("data line driven high");
   a_busy_silent: assert property (write_busy_out |-> sda_oe_n_out)
      else $error("data line pulled during write cycle");
   a_edges_low_clock: assert property ($changed(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 2))
      else $error("data line moved while clock high");
   a_busy_on_stop: assert property ($rose(write_busy_out) |-> s_stop_recent)
      else $error("write cycle without stop");
   a_busy_length: assert property ($fell(write_busy_out) |->
      busy_cnt_q >= WRITE_CYC - 1 && busy_cnt_q <= WRITE_CYC + 1)
      else $error("write cycle length wrong");
   a_wp_no_write: assert property ($rose(write_busy_out) |-> !write_protect_in)
      else $error("write cycle under protection");
   a_ack_stands: assert property ($fell(sda_oe_n_out) |-> s_ack_hold)
      else $error("acknowledge too short");
   a_lock_sticky: assert property (ident_locked_out |=> ident_locked_out)
      else $error("page lock lost");
   // reset must leave the line released and the flags clear
   a_reset_idle: assert property (disable iff (1'b0)
      rst_in |=> sda_oe_n_out && !write_busy_out && !ident_locked_out)
      else $error("bad state after reset");
endmodule

bind eeprom_slave eeprom_slave_props #(.WRITE_CYC(WRITE_CYC)) props_inst (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .write_protect_in(write_protect_in),
   .write_busy_out(write_busy_out), .ident_locked_out(ident_locked_out));

// [bench/link_master.sv]
// bus master model driving the two-wire link
`timescale 1ns/10ps
module link_master #(
   parameter QTR = 12
)(
   output logic scl_out,
   output logic sda_drv_out,
   input  wire  sda_in
);
   // idle: both lines released, link clock stands still; 48 ns period
   initial
   begin
      scl_out = 1'b1;
      sda_drv_out = 1'b1;
   end
   // start or repeated start: data falls while clock high
   task bus_start;
      sda_drv_out = 1'b1;
      #QTR scl_out = 1'b1;
      #(2*QTR) sda_drv_out = 1'b0;
      #(2*QTR) scl_out = 1'b0;
   endtask
   // stop: data rises while clock high
   task bus_stop;
      sda_drv_out = 1'b0;
      #QTR scl_out = 1'b1;
      #(2*QTR) sda_drv_out = 1'b1;
      #(2*QTR);
   endtask
   // one bit: data changes only while clock low
   task bit_io(input logic b, output logic seen);
      sda_drv_out = b;
      #QTR scl_out = 1'b1;
      #QTR seen = sda_in;
      #QTR scl_out = 1'b0;
      #QTR;
   endtask
   // byte out msb first, then release for the ninth slot
   task send_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   // byte in msb first, then our own acknowledge or not
   task recv_byte(output logic [7:0] d, input logic ack_it);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(!ack_it, s);
   endtask
endmodule

// [bench/eeprom_slave_bench.sv]
// self-checking bench for the two-wire memory slave
`timescale 1ns/10ps
module eeprom_slave_bench;
   localparam WCYC = 200;
   logic       ref_clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       write_protect_in = 1'b0;
   logic       ack;
   logic [7:0] d;
   int         err_count = 0;
   int         num_checks = 0;
   int         cycles = 0;
   wire        scl, sda_drv, sda_wire, sda_out, sda_oe_n_out, write_busy_out, ident_locked_out;
   // wired-and line with pull-up
   assign sda_wire = sda_drv & (sda_oe_n_out | sda_out);
   always #2.5 ref_clk_in = ~ref_clk_in;
   eeprom_slave #(.WRITE_CYC(WCYC)) eeprom_slave_inst (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n_out(sda_oe_n_out), .write_protect_in(write_protect_in),
      .write_busy_out(write_busy_out), .ident_locked_out(ident_locked_out));
   link_master link_master_inst (.scl_out(scl), .sda_drv_out(sda_drv), .sda_in(sda_wire));
   // ==========================================================
   // tasks
   task check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task xfer(input logic [7:0] b, input logic exp_ack);
      link_master_inst.send_byte(b, ack);
      check(ack, exp_ack);
   endtask
   task wr(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] v, input logic dack);
      link_master_inst.bus_start();
      xfer(sel, 1'b1);
      xfer(a, 1'b1);
      xfer(v, dack);
      link_master_inst.bus_stop();
   endtask
   // random read: address set by a cut-short write, then repeated start
   task rd(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] exp);
      link_master_inst.bus_start();
      xfer(sel, 1'b1);
      xfer(a, 1'b1);
      link_master_inst.bus_start();
      xfer(sel | 8'h01, 1'b1);
      link_master_inst.recv_byte(d, 1'b0);
      link_master_inst.bus_stop();
      check(d, exp);
   endtask
   // bounded wait so a stuck busy flag is reported, not hung on
   task wait_idle;
      repeat (10) @(posedge ref_clk_in);
      // sampled on the falling edge, away from the edge that moves the flag
      for (int i = 0; i < 2000 && write_busy_out !== 1'b0; i++)
         @(negedge ref_clk_in);
      check(write_busy_out, 1'b0);
   endtask
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         results();
      end
   end
   // ==========================================================
   // test sequence
   initial
   begin
      repeat (4) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      check({sda_oe_n_out, write_busy_out, ident_locked_out}, 8'h04);
      $display("test reset done");
      wr(8'hAA, 8'hA3, 8'h3C, 1'b1);
      repeat (10) @(posedge ref_clk_in);
      check(write_busy_out, 1'b1);
      link_master_inst.bus_start();
      xfer(8'hAA, 1'b0);
      link_master_inst.bus_stop();
      wait_idle();
      rd(8'hAA, 8'hA3, 8'h3C);
      // same low byte, other upper bits: must land elsewhere, checked again below
      wr(8'hA2, 8'hA3, 8'h5A, 1'b1);
      wait_idle();
      rd(8'hA2, 8'hA3, 8'h5A);
      $display("test array write done");
      @(posedge ref_clk_in) write_protect_in <= 1'b1;
      wr(8'hAA, 8'hA3, 8'h55, 1'b0);
      wait_idle();
      rd(8'hAA, 8'hA3, 8'h3C);
      @(posedge ref_clk_in) write_protect_in <= 1'b0;
      $display("test protect done");
      link_master_inst.bus_start();
      xfer(8'h90, 1'b0);
      xfer(8'hAA, 1'b0);
      link_master_inst.bus_stop();
      link_master_inst.bus_start();
      xfer(8'hAA, 1'b1);
      xfer(8'hA3, 1'b1);
      link_master_inst.bus_stop();
      wait_idle();
      rd(8'hAA, 8'hA3, 8'h3C);
      $display("test deselect done");
      wr(8'hB6, 8'h05, 8'h77, 1'b1);
      wait_idle();
      rd(8'hB0, 8'h75, 8'h77);
      wr(8'hB0, 8'h80, 8'h02, 1'b1);
      wait_idle();
      check(ident_locked_out, 1'b1);
      wr(8'hB0, 8'h05, 8'h11, 1'b0);
      wait_idle();
      rd(8'hB0, 8'h05, 8'h77);
      $display("test ident page done");
      results();
   end
endmodule
